// *** rtl/sfw_pkg.sv ***
package sfw_pkg;

	// ----------------------------------------------------------------
	// link timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int INIT_BPS = 9600;
	localparam int BIT_CYCLES_INIT = CLK_HZ / INIT_BPS;
	localparam int CW = 16;

	// ----------------------------------------------------------------
	// protocol bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] SYNC_BYTE = 8'h5a;
	localparam logic [7:0] BAUD_INIT_CODE = 8'h28;
	localparam logic [7:0] CMD_WRITE = 8'h30;
	localparam logic [7:0] ERR_LEAD_A = 8'ha1;
	localparam logic [7:0] ERR_LEAD_B = 8'ha3;
	localparam logic [7:0] ERR_BAUD = 8'h62;
	localparam logic [7:0] ERR_CMD = 8'h63;
	localparam logic [3:0] ERR_LAST = 4'h8;
	localparam logic [3:0] ERR_A_END = 4'h3;
	localparam logic [3:0] ERR_B_END = 4'h6;
	localparam logic [7:0] REC_MARK = 8'h3a;
	localparam logic [7:0] REC_DATA = 8'h00;
	localparam logic [7:0] REC_END = 8'h01;
	localparam logic [7:0] ERASED = 8'hff;

	// ----------------------------------------------------------------
	// blank area
	// ----------------------------------------------------------------
	localparam logic [15:0] BLANK_BASE = 16'hffe0;
	localparam logic [4:0] BLANK_LAST = 5'h1f;
	localparam logic [1:0] ADDR_LAST = 2'h3;

	// ----------------------------------------------------------------
	// state codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SFW_U_IDLE = 2'b00,
		SFW_U_START = 2'b01,
		SFW_U_DATA = 2'b10,
		SFW_U_STOP = 2'b11
	} sfw_uart_st_type;

	typedef enum logic [4:0] {
		SFW_SYNC = 5'b00000,
		SFW_SEND = 5'b00001,
		SFW_BAUD = 5'b00010,
		SFW_CMD = 5'b00011,
		SFW_ADDR = 5'b00100,
		SFW_PROT = 5'b00101,
		SFW_BLANK_RD = 5'b00110,
		SFW_MEM_WAIT = 5'b00111,
		SFW_BLANK_CHK = 5'b01000,
		SFW_CNT_CHK = 5'b01001,
		SFW_PW_RX = 5'b01010,
		SFW_PW_CHK = 5'b01011,
		SFW_H_MARK = 5'b01100,
		SFW_H_LEN = 5'b01101,
		SFW_H_AH = 5'b01110,
		SFW_H_AL = 5'b01111,
		SFW_H_TYPE = 5'b10000,
		SFW_H_DATA = 5'b10001,
		SFW_H_SUM = 5'b10010,
		SFW_SUM_LO = 5'b10011,
		SFW_ERR = 5'b10100,
		SFW_HALT = 5'b10101
	} sfw_st_type;

endpackage : sfw_pkg

// *** rtl/sfw_uart_rx.sv ***
`timescale 1ns/10ps
module sfw_uart_rx #(
	parameter int CW = 16
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic rxd_s,
	input wire logic [CW-1:0] bit_cycles,
	output logic [7:0] data,
	output logic valid,
	output logic ferr
);
	import sfw_pkg::*;

	typedef struct packed {
		sfw_uart_st_type st;
		logic [CW-1:0] cnt;
		logic [2:0] bits;
		logic [7:0] sh;
		logic valid;
		logic ferr;
	} sfw_rx_type;

	sfw_rx_type r_q, r_d;

	always_comb begin
		r_d = r_q;
		r_d.valid = 1'b0;
		r_d.ferr = 1'b0;
		unique case (r_q.st)
			SFW_U_IDLE: begin
				if (!rxd_s) begin
					r_d.st = SFW_U_START;
					r_d.cnt = bit_cycles >> 1;
				end
			end
			SFW_U_START: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else if (rxd_s) begin
					// glitch, not a start bit
					r_d.st = SFW_U_IDLE;
				end else begin
					r_d.st = SFW_U_DATA;
					r_d.cnt = bit_cycles - 1'b1;
					r_d.bits = '0;
				end
			end
			SFW_U_DATA: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					r_d.sh = {rxd_s, r_q.sh[7:1]};
					r_d.cnt = bit_cycles - 1'b1;
					r_d.bits = r_q.bits + 1'b1;
					if (r_q.bits == 3'h7) begin
						r_d.st = SFW_U_STOP;
					end
				end
			end
			SFW_U_STOP: begin
				if (r_q.cnt != '0) begin
					r_d.cnt = r_q.cnt - 1'b1;
				end else begin
					r_d.st = SFW_U_IDLE;
					r_d.valid = rxd_s;
					r_d.ferr = ~rxd_s;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	assign data = r_q.sh;
	assign valid = r_q.valid;
	assign ferr = r_q.ferr;

endmodule : sfw_uart_rx

// *** rtl/sfw_uart_tx.sv ***
`timescale 1ns/10ps
module sfw_uart_tx #(
	parameter int CW = 16
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic [7:0] byte_in,
	input wire logic [CW-1:0] bit_cycles,
	output logic txd,
	output logic done
);
	import sfw_pkg::*;

	typedef struct packed {
		sfw_uart_st_type st;
		logic [CW-1:0] cnt;
		logic [2:0] bits;
		logic [7:0] sh;
		logic line;
		logic done;
	} sfw_tx_type;

	sfw_tx_type t_q, t_d;

	always_comb begin
		t_d = t_q;
		t_d.done = 1'b0;
		unique case (t_q.st)
			SFW_U_IDLE: begin
				t_d.line = 1'b1;
				if (start) begin
					t_d.st = SFW_U_START;
					t_d.sh = byte_in;
					t_d.line = 1'b0;
					t_d.cnt = bit_cycles - 1'b1;
				end
			end
			SFW_U_START, SFW_U_DATA: begin
				if (t_q.cnt != '0) begin
					t_d.cnt = t_q.cnt - 1'b1;
				end else begin
					t_d.cnt = bit_cycles - 1'b1;
					t_d.line = t_q.sh[0];
					t_d.sh = {1'b1, t_q.sh[7:1]};
					if (t_q.st == SFW_U_START) begin
						t_d.st = SFW_U_DATA;
						t_d.bits = '0;
					end else begin
						t_d.bits = t_q.bits + 1'b1;
						if (t_q.bits == 3'h7) begin
							t_d.st = SFW_U_STOP;
							t_d.line = 1'b1;
						end
					end
				end
			end
			SFW_U_STOP: begin
				// done only once the stop bit has fully gone out
				if (t_q.cnt != '0) begin
					t_d.cnt = t_q.cnt - 1'b1;
				end else begin
					t_d.st = SFW_U_IDLE;
					t_d.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			t_q <= '{st: SFW_U_IDLE, line: 1'b1, default: '0};
		end else begin
			t_q <= t_d;
		end
	end

	assign txd = t_q.line;
	assign done = t_q.done;

endmodule : sfw_uart_tx

// *** rtl/sfw_flash_writer.sv ***
`timescale 1ns/10ps
module sfw_flash_writer #(
	parameter int BIT_CYCLES_INIT = sfw_pkg::BIT_CYCLES_INIT,
	parameter logic [7:0] ALT_CODE = 8'h18,
	parameter int ALT_BIT_CYCLES = sfw_pkg::BIT_CYCLES_INIT / 2
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic rxd,
	output logic txd,
	input wire logic read_protect,
	output logic mem_rd_en_q,
	output logic [15:0] mem_rd_addr_q,
	input wire logic [7:0] mem_rd_data,
	output logic prog_valid_q,
	output logic [15:0] prog_addr_q,
	output logic [7:0] prog_data_q,
	output logic halted_q
);
	import sfw_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sync;
		sfw_st_type st;
		sfw_st_type ret;
		logic tx_start;
		logic [7:0] tx_byte;
		logic [CW-1:0] div;
		logic [CW-1:0] new_div;
		logic [3:0] err_cnt;
		logic [7:0] err_code;
		logic [1:0] idx;
		logic [15:0] cnt_addr;
		logic [15:0] pw_addr;
		logic blank;
		logic [4:0] blank_i;
		logic [7:0] pw_n;
		logic [7:0] pw_i;
		logic [7:0] hold;
		logic [7:0] rec_len;
		logic [15:0] rec_addr;
		logic [7:0] rec_type;
		logic [7:0] rec_sum;
		logic [15:0] sum;
		logic mem_en;
		logic [15:0] mem_addr;
		logic prog_v;
		logic [15:0] prog_a;
		logic [7:0] prog_d;
		logic halted;
	} sfw_top_type;

	sfw_top_type s_q, s_d;

	logic [7:0] rx_data;
	logic rx_valid;
	logic rx_ferr;
	logic tx_done;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic sfw_top_type send(input sfw_top_type s,
		input logic [7:0] b, input sfw_st_type ret);
		sfw_top_type o;
		o = s;
		o.tx_start = 1'b1;
		o.tx_byte = b;
		o.ret = ret;
		o.st = SFW_SEND;
		return o;
	endfunction : send

	function automatic sfw_top_type fail(input sfw_top_type s,
		input logic [7:0] code);
		sfw_top_type o;
		o = s;
		o.err_code = code;
		o.err_cnt = '0;
		o.st = SFW_ERR;
		return o;
	endfunction : fail

	function automatic sfw_top_type mem_read(input sfw_top_type s,
		input logic [15:0] a, input sfw_st_type ret);
		sfw_top_type o;
		o = s;
		o.mem_en = 1'b1;
		o.mem_addr = a;
		o.ret = ret;
		o.st = SFW_MEM_WAIT;
		return o;
	endfunction : mem_read

	// ----------------------------------------------------------------
	// serial link
	// ----------------------------------------------------------------
	sfw_uart_rx #(.CW(CW)) u_rx (
		.mclk(mclk),
		.arst_n(arst_n),
		.rxd_s(s_q.sync[1]),
		.bit_cycles(s_q.div),
		.data(rx_data),
		.valid(rx_valid),
		.ferr(rx_ferr)
	);

	sfw_uart_tx #(.CW(CW)) u_tx (
		.mclk(mclk),
		.arst_n(arst_n),
		.start(s_q.tx_start),
		.byte_in(s_q.tx_byte),
		.bit_cycles(s_q.div),
		.txd(txd),
		.done(tx_done)
	);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sync = {s_q.sync[0], rxd};
		s_d.tx_start = 1'b0;
		s_d.prog_v = 1'b0;
		// a framing fault past the sync stage halts silently, except while sending or in the error sequence
		if (rx_ferr && s_q.st != SFW_SYNC && s_q.st != SFW_HALT &&
			s_q.st != SFW_ERR && s_q.st != SFW_SEND) begin
			s_d.st = SFW_HALT;
		end else begin
			unique case (s_q.st)
				SFW_SYNC: begin
					// wrong byte or framing fault: keep listening
					if (rx_valid && rx_data == SYNC_BYTE) begin
						s_d = send(s_d, SYNC_BYTE, SFW_BAUD);
					end
				end
				SFW_SEND: begin
					if (tx_done) begin
						// rate switch waits for the echo's stop bit
						s_d.div = s_q.new_div;
						s_d.st = s_q.ret;
					end
				end
				SFW_BAUD: begin
					if (rx_valid) begin
						if (rx_data == BAUD_INIT_CODE) begin
							s_d.new_div = CW'(BIT_CYCLES_INIT);
							s_d = send(s_d, rx_data, SFW_CMD);
						end else if (rx_data == ALT_CODE) begin
							s_d.new_div = CW'(ALT_BIT_CYCLES);
							s_d = send(s_d, rx_data, SFW_CMD);
						end else begin
							s_d = fail(s_d, ERR_BAUD);
						end
					end
				end
				SFW_CMD: begin
					if (rx_valid) begin
						if (rx_data == CMD_WRITE) begin
							s_d.idx = '0;
							s_d = send(s_d, CMD_WRITE, SFW_ADDR);
						end else begin
							s_d = fail(s_d, ERR_CMD);
						end
					end
				end
				SFW_ADDR: begin
					// four silent bytes: count address then start address
					if (rx_valid) begin
						unique case (s_q.idx)
							2'h0: s_d.cnt_addr[15:8] = rx_data;
							2'h1: s_d.cnt_addr[7:0] = rx_data;
							2'h2: s_d.pw_addr[15:8] = rx_data;
							2'h3: s_d.pw_addr[7:0] = rx_data;
						endcase
						s_d.idx = s_q.idx + 1'b1;
						if (s_q.idx == ADDR_LAST) begin
							s_d.st = SFW_PROT;
						end
					end
				end
				SFW_PROT: begin
					if (read_protect) begin
						s_d.st = SFW_HALT;
					end else begin
						s_d.blank = 1'b1;
						s_d.blank_i = '0;
						s_d.st = SFW_BLANK_RD;
					end
				end
				SFW_BLANK_RD: begin
					s_d = mem_read(s_d, BLANK_BASE + 16'(s_q.blank_i),
						SFW_BLANK_CHK);
				end
				SFW_MEM_WAIT: begin
					s_d.mem_en = 1'b0;
					s_d.st = s_q.ret;
				end
				SFW_BLANK_CHK: begin
					if (mem_rd_data != ERASED) begin
						s_d.blank = 1'b0;
					end
					s_d.blank_i = s_q.blank_i + 1'b1;
					if (s_q.blank_i != BLANK_LAST) begin
						s_d.st = SFW_BLANK_RD;
					end else if (s_q.blank && mem_rd_data == ERASED) begin
						s_d.sum = '0;
						s_d.st = SFW_H_MARK;
					end else begin
						s_d = mem_read(s_d, s_q.cnt_addr, SFW_CNT_CHK);
					end
				end
				SFW_CNT_CHK: begin
					s_d.pw_n = mem_rd_data;
					s_d.pw_i = '0;
					s_d.sum = '0;
					s_d.st = (mem_rd_data == '0) ? SFW_H_MARK : SFW_PW_RX;
				end
				SFW_PW_RX: begin
					if (rx_valid) begin
						s_d.hold = rx_data;
						s_d = mem_read(s_d, s_q.pw_addr + 16'(s_q.pw_i),
							SFW_PW_CHK);
					end
				end
				SFW_PW_CHK: begin
					s_d.pw_i = s_q.pw_i + 1'b1;
					if (mem_rd_data != s_q.hold) begin
						s_d.st = SFW_HALT;
					end else if (s_q.pw_i + 1'b1 == s_q.pw_n) begin
						s_d.st = SFW_H_MARK;
					end else begin
						s_d.st = SFW_PW_RX;
					end
				end
				SFW_H_MARK: begin
					if (rx_valid && rx_data == REC_MARK) begin
						s_d.st = SFW_H_LEN;
					end
				end
				SFW_H_LEN: begin
					if (rx_valid) begin
						s_d.rec_len = rx_data;
						s_d.rec_sum = rx_data;
						s_d.st = SFW_H_AH;
					end
				end
				SFW_H_AH: begin
					if (rx_valid) begin
						s_d.rec_addr[15:8] = rx_data;
						s_d.rec_sum = s_q.rec_sum + rx_data;
						s_d.st = SFW_H_AL;
					end
				end
				SFW_H_AL: begin
					if (rx_valid) begin
						s_d.rec_addr[7:0] = rx_data;
						s_d.rec_sum = s_q.rec_sum + rx_data;
						s_d.st = SFW_H_TYPE;
					end
				end
				SFW_H_TYPE: begin
					if (rx_valid) begin
						s_d.rec_type = rx_data;
						s_d.rec_sum = s_q.rec_sum + rx_data;
						if (rx_data == REC_DATA && s_q.rec_len != '0) begin
							s_d.st = SFW_H_DATA;
						end else if (rx_data == REC_DATA ||
							(rx_data == REC_END && s_q.rec_len == '0)) begin
							s_d.st = SFW_H_SUM;
						end else begin
							s_d.st = SFW_HALT;
						end
					end
				end
				SFW_H_DATA: begin
					if (rx_valid) begin
						s_d.prog_v = 1'b1;
						s_d.prog_a = s_q.rec_addr;
						s_d.prog_d = rx_data;
						s_d.rec_addr = s_q.rec_addr + 1'b1;
						s_d.rec_sum = s_q.rec_sum + rx_data;
						s_d.sum = s_q.sum + 16'(rx_data);
						s_d.rec_len = s_q.rec_len - 1'b1;
						if (s_q.rec_len == 8'h01) begin
							s_d.st = SFW_H_SUM;
						end
					end
				end
				SFW_H_SUM: begin
					if (rx_valid) begin
						if (8'(s_q.rec_sum + rx_data) != '0) begin
							s_d.st = SFW_HALT;
						end else if (s_q.rec_type == REC_END) begin
							s_d = send(s_d, s_q.sum[15:8], SFW_SUM_LO);
						end else begin
							s_d.st = SFW_H_MARK;
						end
					end
				end
				SFW_SUM_LO: begin
					s_d = send(s_d, s_q.sum[7:0], SFW_CMD);
				end
				SFW_ERR: begin
					// three leads of each kind, then three of the cause
					s_d.err_cnt = s_q.err_cnt + 1'b1;
					s_d = send(s_d,
						(s_q.err_cnt < ERR_A_END) ? ERR_LEAD_A :
						(s_q.err_cnt < ERR_B_END) ? ERR_LEAD_B :
						s_q.err_code,
						(s_q.err_cnt == ERR_LAST) ? SFW_HALT : SFW_ERR);
				end
				SFW_HALT: begin
					// no way out but reset
					s_d.halted = 1'b1;
				end
				default: begin
					s_d.st = SFW_HALT;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '{sync: 2'b11, st: SFW_SYNC, ret: SFW_SYNC,
				div: CW'(BIT_CYCLES_INIT), new_div: CW'(BIT_CYCLES_INIT),
				default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign mem_rd_en_q = s_q.mem_en;
	assign mem_rd_addr_q = s_q.mem_addr;
	assign prog_valid_q = s_q.prog_v;
	assign prog_addr_q = s_q.prog_a;
	assign prog_data_q = s_q.prog_d;
	assign halted_q = s_q.halted;

endmodule : sfw_flash_writer

// *** test/sfw_flash_writer_props.sv ***
`timescale 1ns/10ps
module sfw_flash_writer_props #(
	parameter int BIT_CYCLES_INIT = 16,
	parameter logic [7:0] ALT_CODE = 8'h18,
	parameter int ALT_BIT_CYCLES = 8
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic rxd,
	input wire logic txd,
	input wire logic read_protect,
	input wire logic mem_rd_en_q,
	input wire logic [15:0] mem_rd_addr_q,
	input wire logic [7:0] mem_rd_data,
	input wire logic prog_valid_q,
	input wire logic [15:0] prog_addr_q,
	input wire logic [7:0] prog_data_q,
	input wire logic halted_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	// ----------------------------------------------------------------
	// sequences
	// ----------------------------------------------------------------
	// eight cycles is the shortest bit time the bench runs
	sequence s_start_bit;
		(!txd) [*8];
	endsequence
	sequence s_quiet_link;
		txd && !halted_q;
	endsequence

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	a_halt_sticky: assert property (halted_q |=> halted_q)
		else $error("halted state left without reset");
	a_halt_silent: assert property (halted_q |-> txd)
		else $error("transmit while halted");
	a_halt_no_prog: assert property (halted_q |-> !prog_valid_q)
		else $error("programming while halted");
	a_start_bit_len: assert property ($fell(txd) |-> s_start_bit)
		else $error("start bit too short");
	a_prog_one_pulse: assert property (prog_valid_q |=> !prog_valid_q)
		else $error("program pulse longer than one cycle");
	a_prog_no_echo: assert property (prog_valid_q |-> txd)
		else $error("transmit during record reception");
	a_read_is_quiet: assert property (mem_rd_en_q |-> s_quiet_link)
		else $error("memory read while sending or halted");
	a_protect_no_read: assert property (
		read_protect && $past(read_protect) |-> !mem_rd_en_q)
		else $error("memory read under read protection");
endmodule : sfw_flash_writer_props

// *** test/sfw_ctrl_model.sv ***
`timescale 1ns/10ps
module sfw_ctrl_model (
	input wire logic mclk,
	output logic rxd,
	input wire logic txd
);
	int div = 16;
	logic [7:0] rxq[$];
	logic [7:0] sh;

	initial rxd = 1'b1;

	// idle gap first, so a rate change has landed before we talk
	task send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		repeat (div) @(negedge mclk);
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (div) @(negedge mclk);
		end
	endtask : send_byte

	// same frame with a low stop bit, to provoke a receive error
	task send_broken(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b0, b, 1'b0};
		repeat (div) @(negedge mclk);
		for (int i = 0; i < 10; i++) begin
			rxd = f[i];
			repeat (div) @(negedge mclk);
		end
		rxd = 1'b1;
	endtask : send_broken

	// mid-bit sampling; a low stop bit drops the byte
	always begin
		@(negedge txd);
		repeat (div / 2) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(negedge mclk);
			sh[i] = txd;
		end
		repeat (div) @(negedge mclk);
		if (txd === 1'b1) rxq.push_back(sh);
	end
endmodule : sfw_ctrl_model

// *** test/testbench.sv ***
`timescale 1ns/10ps
module testbench;
	import sfw_pkg::*;
	localparam int DIV0 = 16;
	localparam int DIV1 = 8;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic read_protect = 1'b0;
	logic [7:0] mem_rd_data = 8'hff;
	wire logic rxd;
	logic txd, mem_rd_en_q, prog_valid_q, halted_q;
	logic [15:0] mem_rd_addr_q, prog_addr_q;
	logic [7:0] prog_data_q;
	logic [7:0] mem [0:65535];
	logic [23:0] pq[$];
	int fails = 0;
	int checks_done = 0;

	initial forever #12.5 mclk = ~mclk;

	sfw_flash_writer #(.BIT_CYCLES_INIT(DIV0), .ALT_CODE(8'h18),
		.ALT_BIT_CYCLES(DIV1)) sfw_flash_writer_inst (.mclk(mclk),
		.arst_n(arst_n), .rxd(rxd), .txd(txd), .read_protect(read_protect),
		.mem_rd_en_q(mem_rd_en_q), .mem_rd_addr_q(mem_rd_addr_q),
		.mem_rd_data(mem_rd_data), .prog_valid_q(prog_valid_q),
		.prog_addr_q(prog_addr_q), .prog_data_q(prog_data_q),
		.halted_q(halted_q));
	sfw_ctrl_model sfw_ctrl_model_inst (.mclk(mclk), .rxd(rxd), .txd(txd));

	// one-cycle read latency: data lands at the falling edge after request
	always @(negedge mclk) begin
		if (mem_rd_en_q === 1'b1) begin
			mem_rd_data <= mem[mem_rd_addr_q];
		end
	end
	// program pulses are looked at mid-cycle, where they have settled
	always @(negedge mclk) begin
		if (prog_valid_q === 1'b1) begin
			pq.push_back({prog_addr_q, prog_data_q});
		end
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task complete_run;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : chk

	task do_reset(input logic prot);
		@(negedge mclk);
		arst_n = 1'b0;
		read_protect = prot;
		sfw_ctrl_model_inst.div = DIV0;
		sfw_ctrl_model_inst.rxq.delete();
		pq.delete();
		// every location starts erased, so no record rewrites data
		for (int i = 0; i < 65536; i++) mem[i] = ERASED;
		repeat (16) @(negedge mclk);
		chk("txd in reset", 24'h1, {23'h0, txd});
		arst_n = 1'b1;
		repeat (4) @(negedge mclk);
	endtask : do_reset

	task tx(input logic [7:0] b);
		sfw_ctrl_model_inst.send_byte(b);
	endtask : tx

	task rx(input logic [7:0] exp);
		int n;
		n = 0;
		while (sfw_ctrl_model_inst.rxq.size() == 0 && n < 4000) begin
			@(negedge mclk);
			n++;
		end
		if (n == 4000) begin
			$display("FAIL reply expected %h seen none", exp);
			fails++;
			complete_run();
		end else begin
			chk("reply", {16'h0, exp}, {16'h0, sfw_ctrl_model_inst.rxq.pop_front()});
		end
	endtask : rx

	task quiet(input int n);
		repeat (n) @(negedge mclk);
		chk("silence", 24'h0, 24'(sfw_ctrl_model_inst.rxq.size()));
	endtask : quiet

	task sync;
		tx(8'h00);
		quiet(400);
		tx(SYNC_BYTE);
		rx(SYNC_BYTE);
	endtask : sync

	task enter(input logic [7:0] rate, input int d);
		sync();
		tx(rate);
		rx(rate);
		// the device switches only once its echo's stop bit has gone out
		repeat (DIV0) @(negedge mclk);
		sfw_ctrl_model_inst.div = d;
		tx(CMD_WRITE);
		rx(CMD_WRITE);
	endtask : enter

	task addrs;
		tx(8'h01);
		tx(8'h00);
		tx(8'h02);
		tx(8'h00);
		quiet(300);
	endtask : addrs

	task send_rec(input logic [7:0] body[$]);
		logic [7:0] s;
		s = 8'h00;
		tx(REC_MARK);
		foreach (body[i]) begin
			tx(body[i]);
			s = s - body[i];
		end
		tx(s);
	endtask : send_rec

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_write_blank;
		do_reset(1'b0);
		enter(8'h18, DIV1);
		addrs();
		tx(8'h55);
		// a normal image, never the top 32 bytes alone
		send_rec('{8'h02, 8'h12, 8'h34, REC_DATA, 8'haa, 8'h55});
		send_rec('{8'h00, 8'h00, 8'h00, REC_END});
		rx(8'h00);
		rx(8'hff);
		chk("prog count", 24'h2, 24'(pq.size()));
		chk("prog 0", 24'h1234aa, pq[0]);
		chk("prog 1", 24'h123555, pq[1]);
		tx(CMD_WRITE);
		rx(CMD_WRITE);
	endtask : t_write_blank

	task t_password(input logic good);
		do_reset(1'b0);
		mem[16'hffe0] = 8'h12;
		mem[16'h0100] = 8'h02;
		mem[16'h0200] = 8'hc3;
		mem[16'h0201] = 8'h3c;
		enter(BAUD_INIT_CODE, DIV0);
		addrs();
		tx(8'hc3);
		tx(good ? 8'h3c : 8'h99);
		if (good) begin
			send_rec('{8'h01, 8'h40, 8'h00, REC_DATA, 8'h5e});
			send_rec('{8'h00, 8'h00, 8'h00, REC_END});
			rx(8'h00);
			rx(8'h5e);
			chk("prog pw", 24'h40005e, pq[0]);
		end
		quiet(400);
		chk("halted", {23'h0, !good}, {23'h0, halted_q});
	endtask : t_password

	task t_err_code(input logic bad_rate);
		logic [7:0] codes [3];
		codes = '{ERR_LEAD_A, ERR_LEAD_B, bad_rate ? ERR_BAUD : ERR_CMD};
		do_reset(1'b0);
		sync();
		if (bad_rate) begin
			tx(8'h77);
		end else begin
			tx(BAUD_INIT_CODE);
			rx(BAUD_INIT_CODE);
			tx(8'h44);
		end
		foreach (codes[i]) repeat (3) rx(codes[i]);
		quiet(400);
		chk("halted", 24'h1, {23'h0, halted_q});
	endtask : t_err_code

	task t_bad_record;
		do_reset(1'b0);
		enter(BAUD_INIT_CODE, DIV0);
		addrs();
		tx(REC_MARK);
		tx(8'h01);
		tx(8'h00);
		tx(8'h10);
		tx(REC_DATA);
		tx(8'h77);
		tx(8'h00);
		quiet(600);
		chk("halted", 24'h1, {23'h0, halted_q});
	endtask : t_bad_record

	task t_protect;
		do_reset(1'b1);
		enter(BAUD_INIT_CODE, DIV0);
		addrs();
		chk("halted", 24'h1, {23'h0, halted_q});
		do_reset(1'b0);
		chk("halt cleared", 24'h0, {23'h0, halted_q});
	endtask : t_protect

	task t_rx_error;
		do_reset(1'b0);
		enter(BAUD_INIT_CODE, DIV0);
		tx(8'h01);
		sfw_ctrl_model_inst.send_broken(8'h00);
		quiet(400);
		chk("halted", 24'h1, {23'h0, halted_q});
	endtask : t_rx_error

	initial begin
		t_write_blank();
		t_password(1'b1);
		t_password(1'b0);
		t_err_code(1'b1);
		t_err_code(1'b0);
		t_bad_record();
		t_rx_error();
		t_protect();
		complete_run();
	end
endmodule : testbench

bind sfw_flash_writer sfw_flash_writer_props #(
	.BIT_CYCLES_INIT(BIT_CYCLES_INIT), .ALT_CODE(ALT_CODE),
	.ALT_BIT_CYCLES(ALT_BIT_CYCLES)) sfw_flash_writer_props_inst (
	.mclk(mclk), .arst_n(arst_n), .rxd(rxd), .txd(txd),
	.read_protect(read_protect), .mem_rd_en_q(mem_rd_en_q),
	.mem_rd_addr_q(mem_rd_addr_q), .mem_rd_data(mem_rd_data),
	.prog_valid_q(prog_valid_q), .prog_addr_q(prog_addr_q),
	.prog_data_q(prog_data_q), .halted_q(halted_q));
